// *** shared/tses_pkg.sv ***
// Constants shared by the transmitter event source logic
package tses_pkg;

  // ---------------------------------------------------------------
  // Event bit positions in the pending and enable vectors
  // ---------------------------------------------------------------
  localparam int unsigned EVT_NUM        = 8;
  localparam int unsigned EVT_CONNECT    = 0;
  localparam int unsigned EVT_DISCONNECT = 1;
  localparam int unsigned EVT_LINK_UP    = 2;
  localparam int unsigned EVT_LINK_DOWN  = 3;
  localparam int unsigned EVT_VSYNC      = 4;
  localparam int unsigned EVT_CIPHER14   = 5;
  localparam int unsigned EVT_TIMER14    = 6;
  localparam int unsigned EVT_TIMER22    = 7;

  // ---------------------------------------------------------------
  // Optional sources, in the order of the opt_event input
  // ---------------------------------------------------------------
  localparam int unsigned OPT_NUM        = 3;
  localparam int unsigned OPT_BASE       = EVT_CIPHER14;

  // ---------------------------------------------------------------
  // Reset values and synchroniser depth
  // ---------------------------------------------------------------
  localparam logic [EVT_NUM-1:0] PEND_RST   = 8'h00;
  localparam logic               IRQ_RST    = 1'b0;
  localparam logic               LEVEL_RST  = 1'b0;
  localparam int unsigned        SYNC_DEPTH = 2;

endpackage : tses_pkg

// *** logic/tses_edge.sv ***
// Input synchroniser with registered level and edge pulses
`timescale 1ns/1ns
module tses_edge #(
  parameter int unsigned STAGES = tses_pkg::SYNC_DEPTH,
  parameter bit          SYNC   = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import tses_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] sync;
    logic              prev;
    logic              rise;
    logic              fall;
  } tses_edge_state_t;

  tses_edge_state_t s_q;
  tses_edge_state_t s_d;
  logic             sample;

  // Refuse a synchroniser too short to settle a pin
  if (STAGES < 2)
  begin : g_bad_stages
    $error("tses_edge: STAGES must be at least 2");
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    sample    = SYNC ? s_q.sync[STAGES-1] : din;
    s_d       = s_q;
    s_d.sync  = {s_q.sync[STAGES-2:0], din};
    s_d.prev  = sample;
    s_d.rise  = sample & ~s_q.prev;
    s_d.fall  = ~sample & s_q.prev;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '{sync: '0, prev: LEVEL_RST, rise: 1'b0, fall: 1'b0};
    else
      s_q <= s_d;
  end

  assign level = s_q.prev;
  assign rise  = s_q.rise;
  assign fall  = s_q.fall;

  a_rise_pulse : assert property (@(posedge clk) disable iff (!rst_n) // RULE_01 RULE_04
    rise |-> level && !$past(level))
    else $error("rise pulse without a low to high step");

endmodule : tses_edge

// *** logic/tses_events.sv ***
// Event sources, sticky pending flags and interrupt output
// Notes on behaviour
// RULE_01: Cable sense rising reports connect; falling reports disconnect.
// RULE_02: Line-clock status bit becomes 1 once the line clock is stable.
// RULE_03: Line-clock status bit returns to 0 when the line clock is unstable.
// RULE_04: Each status change raises link up or link down event separately.
// RULE_05: Rising edge of video vertical sync raises a vertical-sync event.
// RULE_06: Older cipher and its timer events exist only when that engine is built.
// RULE_07: Newer engine timer event exists only when that engine is built.
// RULE_08: Events stay pending until cleared; enabled ones form one level interrupt.
`timescale 1ns/1ns
module tses_events #(
  parameter bit INCL_P14 = 1'b1,
  parameter bit INCL_P22 = 1'b1
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic                           cable_sense,
  input  wire logic                           line_clk_stable,
  input  wire logic                           vid_vsync,
  input  wire logic [tses_pkg::OPT_NUM-1:0]   opt_event,
  input  wire logic [tses_pkg::EVT_NUM-1:0]   irq_enable,
  input  wire logic [tses_pkg::EVT_NUM-1:0]   irq_clear,
  output logic                                irq,
  output logic [tses_pkg::EVT_NUM-1:0]        irq_pending,
  output logic                                cable_connected,
  output logic                                line_clk_status
);
  import tses_pkg::*;

  typedef struct packed {
    logic [EVT_NUM-1:0] pend;
    logic               irq;
  } tses_state_t;

  localparam logic [OPT_NUM-1:0] OPT_INCL = {INCL_P22, INCL_P14, INCL_P14};

  tses_state_t        s_q;
  tses_state_t        s_d;
  logic [EVT_NUM-1:0] evt;
  logic               cs_rise;
  logic               cs_fall;
  logic               lk_rise;
  logic               lk_fall;
  logic               vs_rise;
  logic [OPT_NUM-1:0] opt_rise;

  // ---------------------------------------------------------------
  // Edge detection of the pin-level sources
  // ---------------------------------------------------------------
  tses_edge #(.STAGES(SYNC_DEPTH), .SYNC(1'b1)) u_cable (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (cable_sense),
    .level (cable_connected),
    .rise  (cs_rise),
    .fall  (cs_fall)
  );

  // Status bit tracks the synchronised stable indication
  tses_edge #(.STAGES(SYNC_DEPTH), .SYNC(1'b1)) u_link (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (line_clk_stable),
    .level (line_clk_status), // RULE_02 RULE_03
    .rise  (lk_rise),
    .fall  (lk_fall)
  );

  tses_edge #(.STAGES(SYNC_DEPTH), .SYNC(1'b1)) u_vsync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (vid_vsync),
    .level (),
    .rise  (vs_rise),
    .fall  ()
  );

  // ---------------------------------------------------------------
  // Optional engine sources, same clock, no synchroniser
  // ---------------------------------------------------------------
  for (genvar i = 0; i < OPT_NUM; i++)
  begin : g_opt
    if (OPT_INCL[i])
    begin : g_on
      tses_edge #(.STAGES(SYNC_DEPTH), .SYNC(1'b0)) u_opt (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (opt_event[i]),
        .level (),
        .rise  (opt_rise[i]),
        .fall  ()
      );
    end
    else
    begin : g_off
      assign opt_rise[i] = 1'b0; // RULE_06 RULE_07
    end
  end

  // ---------------------------------------------------------------
  // Pending flags and interrupt
  // ---------------------------------------------------------------
  always_comb
  begin
    evt                 = '0;
    evt[EVT_CONNECT]    = cs_rise; // RULE_01
    evt[EVT_DISCONNECT] = cs_fall; // RULE_01
    evt[EVT_LINK_UP]    = lk_rise; // RULE_04
    evt[EVT_LINK_DOWN]  = lk_fall; // RULE_04
    evt[EVT_VSYNC]      = vs_rise; // RULE_05
    evt[EVT_CIPHER14]   = opt_rise[0] & INCL_P14; // RULE_06
    evt[EVT_TIMER14]    = opt_rise[1] & INCL_P14; // RULE_06
    evt[EVT_TIMER22]    = opt_rise[2] & INCL_P22; // RULE_07
    s_d                 = s_q;
    // A new event wins over a clear in the same cycle
    s_d.pend            = (s_q.pend & ~irq_clear) | evt; // RULE_08
    s_d.irq             = |(s_d.pend & irq_enable); // RULE_08
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '{pend: PEND_RST, irq: IRQ_RST};
    else
      s_q <= s_d;
  end

  assign irq         = s_q.irq;
  assign irq_pending = s_q.pend;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence stable_run;
    line_clk_stable [*5];
  endsequence

  sequence unstable_run;
    !line_clk_stable [*5];
  endsequence

  a_connect_flag : assert property ( // RULE_01
    $rose(cable_connected) |=> irq_pending[EVT_CONNECT])
    else $error("connect event not latched");

  a_disconnect_flag : assert property ( // RULE_01
    $fell(cable_connected) |=> irq_pending[EVT_DISCONNECT])
    else $error("disconnect event not latched");

  a_status_set : assert property ( // RULE_02
    stable_run |=> line_clk_status)
    else $error("status bit not set after stable clock");

  a_status_clear : assert property ( // RULE_03
    unstable_run |=> !line_clk_status)
    else $error("status bit not cleared after unstable clock");

  a_link_updown : assert property ( // RULE_04
    // The new status level picks the flag; the other may still be pending
    $changed(line_clk_status) |=>
      ($past(line_clk_status) ? irq_pending[EVT_LINK_UP]
                              : irq_pending[EVT_LINK_DOWN]))
    else $error("link change not latched with its direction");

  a_vsync_flag : assert property ( // RULE_05
    vs_rise |=> irq_pending[EVT_VSYNC])
    else $error("vertical sync event not latched");

  a_p14_absent : assert property ( // RULE_06
    !INCL_P14 |-> !irq_pending[EVT_CIPHER14] && !irq_pending[EVT_TIMER14])
    else $error("absent engine raised an event");

  a_p22_absent : assert property ( // RULE_07
    !INCL_P22 |-> !irq_pending[EVT_TIMER22])
    else $error("absent timer raised an event");

  a_pend_sticky : assert property ( // RULE_08
    (irq_pending != '0) ##0 (irq_clear == '0) |=> ((irq_pending & $past(irq_pending))
      == $past(irq_pending)))
    else $error("pending flag lost without a clear");

  a_irq_level : assert property ( // RULE_08
    irq == |(irq_pending & $past(irq_enable)))
    else $error("interrupt does not match enabled pending flags");

endmodule : tses_events

// *** test/tses_host.sv ***
// Host model that acknowledges pending interrupts after a set delay
`timescale 1ns/1ns
module tses_host (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_delay,
  input  wire logic       irq,
  input  wire logic [7:0] irq_pending,
  output logic      [7:0] irq_clear
);
  logic       busy_q;
  logic [3:0] cnt_q;
  always @(posedge clk)
  begin
    irq_clear <= 8'h00;
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      cnt_q  <= 4'h0;
    end
    else if (busy_q)
    begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == ack_delay)
      begin
        irq_clear <= irq_pending;
        busy_q    <= 1'b0;
      end
    end
    else if (ack_en && irq && irq_clear == 8'h00)
    begin
      busy_q <= 1'b1;
      cnt_q  <= 4'h0;
    end
  end
endmodule : tses_host

// *** test/tb.sv ***
// Self-checking bench for the event sources
`timescale 1ns/1ns
module tb;
  import tses_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cable_sense = 1'b0;
  logic       line_clk_stable = 1'b0;
  logic       vid_vsync = 1'b0;
  logic [2:0] opt_event = 3'h0;
  logic [7:0] irq_enable = 8'h00;
  logic [7:0] clr_tb = 8'h00;
  logic [7:0] clr_host;
  logic       ack_en = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic       irq;
  logic [7:0] irq_pending;
  logic       cable_connected;
  logic       line_clk_status;
  logic [7:0] exp_pend = 8'h00;
  logic [2:0] old_opt;
  logic [7:0] c;
  int         fails = 0;
  int         cmp_count = 0;

  always #25 clk = ~clk;

  tses_events u_tses_events (.clk(clk), .rst_n(rst_n), .cable_sense(cable_sense),
    .line_clk_stable(line_clk_stable), .vid_vsync(vid_vsync), .opt_event(opt_event),
    .irq_enable(irq_enable), .irq_clear(clr_tb | clr_host), .irq(irq),
    .irq_pending(irq_pending), .cable_connected(cable_connected),
    .line_clk_status(line_clk_status));
  tses_host u_tses_host (.clk(clk), .rst_n(rst_n), .ack_en(ack_en), .ack_delay(ack_delay),
    .irq(irq), .irq_pending(irq_pending), .irq_clear(clr_host));

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic check_all();
    check(irq_pending, exp_pend, "pending");
    check({7'h00, irq}, {7'h00, |(exp_pend & irq_enable)}, "irq");
  endtask : check_all

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  // Pin change, then the flag after four edges
  task automatic pin_evt(input int sel, input logic v, input int idx);
    case (sel)
      0: cable_sense = v;
      1: line_clk_stable = v;
      default: vid_vsync = v;
    endcase
    cyc(4);
    if (idx >= 0) exp_pend[idx] = 1'b1;
    check_all();
  endtask : pin_evt

  task automatic clr_all();
    clr_tb = 8'hff;
    cyc(1);
    clr_tb = 8'h00;
    exp_pend = 8'h00;
    check_all();
    irq_enable = 8'($urandom);
    cyc(1);
  endtask : clr_all

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h84a4));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    check_all();
    check({6'h00, cable_connected, line_clk_status}, 8'h00, "levels");
    $display("test reset done");
    clr_all();
    pin_evt(0, 1'b1, EVT_CONNECT);
    check({7'h00, cable_connected}, 8'h01, "cable");
    pin_evt(0, 1'b0, EVT_DISCONNECT);
    $display("test cable done");
    clr_all();
    pin_evt(1, 1'b1, EVT_LINK_UP);
    check({7'h00, line_clk_status}, 8'h01, "status");
    pin_evt(1, 1'b0, EVT_LINK_DOWN);
    check({7'h00, line_clk_status}, 8'h00, "status");
    $display("test link done");
    clr_all();
    pin_evt(2, 1'b1, EVT_VSYNC);
    pin_evt(2, 1'b0, -1);
    $display("test vsync done");
    for (int i = 0; i < OPT_NUM; i++)
    begin
      opt_event[i] = 1'b1;
      cyc(2);
      exp_pend[OPT_BASE+i] = 1'b1;
      check_all();
    end
    opt_event = 3'h0;
    clr_all();
    opt_event[0] = 1'b1;
    cyc(1);
    clr_tb = 8'h20;
    cyc(1);
    clr_tb = 8'h00;
    exp_pend[OPT_BASE] = 1'b1;
    check_all();
    $display("test set over clear done");
    opt_event = 3'h0;
    clr_all();
    ack_en = 1'b1;
    ack_delay = 4'($urandom);
    irq_enable = 8'hff;
    pin_evt(2, 1'b1, EVT_VSYNC);
    cyc(int'(ack_delay) + 4);
    exp_pend = 8'h00;
    check_all();
    ack_en = 1'b0;
    $display("test host ack done");
    for (int k = 0; k < 30; k++)
    begin
      old_opt = opt_event;
      opt_event = 3'($urandom);
      irq_enable = 8'($urandom);
      cyc(2);
      exp_pend[7:5] = exp_pend[7:5] | (opt_event & ~old_opt);
      check_all();
      c = 8'($urandom);
      clr_tb = c;
      cyc(1);
      clr_tb = 8'h00;
      exp_pend = exp_pend & ~c;
      check_all();
    end
    $display("test random done");
    complete_run();
  end
endmodule : tb
